// File: icu_pkg.sv
/*
  Shared constants and types for the integer compute unit: operation codes,
  operand widths, divider constants and unit states.
  Assumes the decode stage maps each instruction onto one icu_op_e code.
*/
package icu_pkg;

  localparam int unsigned DATA_W  = 32;
  localparam int unsigned IMM_W   = 16;
  localparam int unsigned SHAMT_W = 5;
  localparam int unsigned PROD_W  = 64;
  localparam int unsigned DIV_CNT_W = 6;
  localparam logic [5:0]  DIV_STEPS = 6'h20;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [31:0] ONE_WORD  = 32'h0000_0001;
  localparam logic [15:0] ZERO_HALF = 16'h0000;

  typedef enum logic [4:0] {
    ICU_OP_SUM_IMM_TRAP,
    ICU_OP_SUM_IMM_NOTRAP,
    ICU_OP_LT_IMM_S,
    ICU_OP_LT_IMM_U,
    ICU_OP_AND_IMM,
    ICU_OP_OR_IMM,
    ICU_OP_XOR_IMM,
    ICU_OP_LOAD_TOP_IMM,
    ICU_OP_SUM_REG_TRAP,
    ICU_OP_SUM_REG_NOTRAP,
    ICU_OP_DIFF_TRAP,
    ICU_OP_DIFF_NOTRAP,
    ICU_OP_LT_REG_S,
    ICU_OP_LT_REG_U,
    ICU_OP_AND_REG,
    ICU_OP_OR_REG,
    ICU_OP_XOR_REG,
    ICU_OP_NOR_REG,
    ICU_OP_SHL_CONST,
    ICU_OP_SHR_ZERO_CONST,
    ICU_OP_SHR_SIGN_CONST,
    ICU_OP_SHL_VAR,
    ICU_OP_SHR_ZERO_VAR,
    ICU_OP_SHR_SIGN_VAR,
    ICU_OP_PRODUCT_S,
    ICU_OP_PRODUCT_U,
    ICU_OP_QUOTIENT_S,
    ICU_OP_QUOTIENT_U,
    ICU_OP_READ_TOP,
    ICU_OP_READ_BOTTOM,
    ICU_OP_WRITE_TOP,
    ICU_OP_WRITE_BOTTOM
  } icu_op_e;

  typedef enum logic [1:0] {
    ICU_ST_IDLE,
    ICU_ST_DIVIDE,
    ICU_ST_DONE
  } icu_state_e;

endpackage : icu_pkg

// File: icu_shifter.sv
/*
  Barrel shifter: left with zero fill, right with zero or sign fill.
  Assumes the shift amount is already selected by the caller.
*/
`timescale 1ns/1ps
module icu_shifter
  import icu_pkg::*;
(
  // Operand and control
  input  wire logic [icu_pkg::DATA_W-1:0]  value_in,
  input  wire logic [icu_pkg::SHAMT_W-1:0] amount_in,
  input  wire logic                        go_right_in,
  input  wire logic                        sign_fill_in,
  // Result
  output logic      [icu_pkg::DATA_W-1:0]  result_out
);

  wire logic                       fill_bit;
  wire logic signed [DATA_W:0]     wide_value;
  wire logic signed [DATA_W:0]     wide_shifted;
  wire logic        [DATA_W-1:0]   left_value;

  // Extend by one bit so one arithmetic shift covers both right kinds
  assign fill_bit     = sign_fill_in & value_in[DATA_W-1];
  assign wide_value   = {fill_bit, value_in};
  assign wide_shifted = wide_value >>> amount_in;
  assign left_value   = value_in << amount_in;
  assign result_out   = go_right_in ? wide_shifted[DATA_W-1:0] : left_value;

endmodule : icu_shifter

// File: icu_divider.sv
/*
  Restoring divider on magnitudes, one quotient bit per clock.
  Assumes start_in pulses only while busy_out is low; signs are fixed up by
  the caller.
*/
`timescale 1ns/1ps
module icu_divider
  import icu_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       rst_n_in,
  // Request
  input  wire logic                       start_in,
  input  wire logic [icu_pkg::DATA_W-1:0] dividend_in,
  input  wire logic [icu_pkg::DATA_W-1:0] divisor_in,
  // Answer
  output logic                            busy_out,
  output logic                            done_out,
  output logic      [icu_pkg::DATA_W-1:0] quotient_out,
  output logic      [icu_pkg::DATA_W-1:0] remainder_out
);

  logic [DIV_CNT_W-1:0] count;
  logic [DATA_W-1:0]    divisor;
  wire  logic [DATA_W:0]   trial_rem;
  wire  logic [DATA_W:0]   trial_diff;
  wire  logic              fits;

  assign trial_rem  = {remainder_out, quotient_out[DATA_W-1]};
  assign trial_diff = trial_rem - {1'b0, divisor};
  assign fits       = ~trial_diff[DATA_W];
  assign busy_out   = (count != DIV_CNT_W'(0));

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count         <= '0;
      divisor       <= ZERO_WORD;
      quotient_out  <= ZERO_WORD;
      remainder_out <= ZERO_WORD;
      done_out      <= 1'b0;
    end
    else
    begin
      done_out <= busy_out && (count == DIV_CNT_W'(1));
      if (start_in && !busy_out)
      begin
        count         <= DIV_STEPS;
        divisor       <= divisor_in;
        quotient_out  <= dividend_in;
        remainder_out <= ZERO_WORD;
      end
      else if (busy_out)
      begin
        count         <= count - DIV_CNT_W'(1);
        remainder_out <= fits ? trial_diff[DATA_W-1:0] : trial_rem[DATA_W-1:0];
        quotient_out  <= {quotient_out[DATA_W-2:0], fits};
      end
    end
  end

endmodule : icu_divider

// File: icu_compute_unit.sv
/*
  Integer compute unit: immediate and register arithmetic and logic, shifts,
  multiply and divide into the top/bottom special pair, and moves to and
  from that pair.
  Assumes decode presents one operation with operands and holds it while
  busy_out is high; the register file writes result_out when write_out is high.
*/
`timescale 1ns/1ps
// Behaviour
// RQ1 - Operand two is a register or the 16-bit immediate field.
// RQ2 - Trapping adds give 32-bit sum; signed overflow traps; immediate sign-extended.
// RQ3 - Non-trapping adds give the same sum and never trap.
// RQ4 - Signed less-than immediate: sign-extend, signed compare, write 1 or 0.
// RQ5 - Unsigned less-than immediate: sign-extend, unsigned compare, never trap.
// RQ6 - AND, OR, XOR immediate zero-extend the immediate to 32 bits.
// RQ7 - Load top immediate puts immediate in upper half, lower half zero.
// RQ8 - Register subtracts write 32-bit difference; only trapping form flags overflow.
// RQ9 - Register less-than compares signed or unsigned, writes 1 or 0.
// RQ10 - Register AND, OR, XOR and NOR of both sources.
// RQ11 - Constant left shift by shift field, zero fill.
// RQ12 - Constant right logical shift by shift field, zero fill.
// RQ13 - Constant right arithmetic shift replicates the sign bit.
// RQ14 - Variable shifts use low 5 bits of source A, same fills.
// RQ15 - Signed and unsigned multiply place 64-bit product in the special pair.
// RQ16 - Divides: quotient to bottom special, remainder to top special.
// RQ17 - Read operations copy top or bottom special into destination.
// RQ18 - Write operations copy source register into top or bottom special.
// RQ19 - Subtract is source A minus source B; overflow judged on that order.
// RQ20 - Trapping overflow leaves destination unwritten and signals the exception.
module icu_compute_unit
  import icu_pkg::*;
(
  // Clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  // Operation from decode
  input  wire logic                        op_valid_in,
  input  wire icu_pkg::icu_op_e            op_in,
  input  wire logic [icu_pkg::DATA_W-1:0]  source_a_in,
  input  wire logic [icu_pkg::DATA_W-1:0]  source_b_in,
  input  wire logic [icu_pkg::IMM_W-1:0]   immediate_in,
  input  wire logic [icu_pkg::SHAMT_W-1:0] shift_count_in,
  // Result toward the register file
  output logic                             busy_out,
  output logic                             write_out,
  output logic      [icu_pkg::DATA_W-1:0]  result_out,
  output logic                             overflow_trap_out,
  // Special pair, visible for debug
  output logic      [icu_pkg::DATA_W-1:0]  product_top_half_out,
  output logic      [icu_pkg::DATA_W-1:0]  product_bottom_half_out
);

  icu_state_e state;
  icu_state_e next_state;

  logic [DATA_W-1:0] product_top_half;
  logic [DATA_W-1:0] product_bottom_half;
  logic              neg_quotient;
  logic              neg_remainder;

  // Immediate extensions
  wire logic [DATA_W-1:0] imm_sign_ext;
  wire logic [DATA_W-1:0] imm_zero_ext;
  wire logic [DATA_W-1:0] imm_top;
  wire logic              use_imm;
  wire logic [DATA_W-1:0] operand_b;

  assign imm_sign_ext = {{(DATA_W-IMM_W){immediate_in[IMM_W-1]}}, immediate_in}; // RQ2
  assign imm_zero_ext = {ZERO_HALF, immediate_in}; // RQ6
  assign imm_top      = {immediate_in, ZERO_HALF}; // RQ7

  assign use_imm = (op_in == ICU_OP_SUM_IMM_TRAP) || (op_in == ICU_OP_SUM_IMM_NOTRAP)
                || (op_in == ICU_OP_LT_IMM_S) || (op_in == ICU_OP_LT_IMM_U);
  // Second operand is register or sign-extended immediate
  assign operand_b = use_imm ? imm_sign_ext : source_b_in; // RQ1

  // Adder and subtractor
  wire logic [DATA_W-1:0] sum_value;
  wire logic [DATA_W-1:0] diff_value;
  wire logic              sum_overflow;
  wire logic              diff_overflow;

  assign sum_value  = source_a_in + operand_b; // RQ2 RQ3
  assign diff_value = source_a_in - source_b_in; // RQ19 RQ8
  assign sum_overflow  = (source_a_in[DATA_W-1] == operand_b[DATA_W-1])
                      && (sum_value[DATA_W-1] != source_a_in[DATA_W-1]); // RQ2
  assign diff_overflow = (source_a_in[DATA_W-1] != source_b_in[DATA_W-1])
                      && (diff_value[DATA_W-1] != source_a_in[DATA_W-1]); // RQ19

  // Comparisons
  wire logic less_signed;
  wire logic less_unsigned;
  wire logic [DATA_W-1:0] less_s_word;
  wire logic [DATA_W-1:0] less_u_word;

  assign less_signed   = $signed(source_a_in) < $signed(operand_b); // RQ4 RQ9
  assign less_unsigned = source_a_in < operand_b; // RQ5 RQ9
  assign less_s_word   = less_signed ? ONE_WORD : ZERO_WORD;
  assign less_u_word   = less_unsigned ? ONE_WORD : ZERO_WORD;

  // Shifter control
  wire logic               shift_var;
  wire logic               shift_right;
  wire logic               shift_sign;
  wire logic [SHAMT_W-1:0] shift_amount;
  wire logic [DATA_W-1:0]  shift_value;

  assign shift_var   = (op_in == ICU_OP_SHL_VAR) || (op_in == ICU_OP_SHR_ZERO_VAR)
                    || (op_in == ICU_OP_SHR_SIGN_VAR);
  assign shift_right = (op_in == ICU_OP_SHR_ZERO_CONST) || (op_in == ICU_OP_SHR_SIGN_CONST)
                    || (op_in == ICU_OP_SHR_ZERO_VAR) || (op_in == ICU_OP_SHR_SIGN_VAR);
  assign shift_sign  = (op_in == ICU_OP_SHR_SIGN_CONST) || (op_in == ICU_OP_SHR_SIGN_VAR); // RQ13
  assign shift_amount = shift_var ? source_a_in[SHAMT_W-1:0] : shift_count_in; // RQ14

  icu_shifter u_shifter (
    .value_in     (source_b_in),
    .amount_in    (shift_amount),
    .go_right_in  (shift_right),
    .sign_fill_in (shift_sign),
    .result_out   (shift_value)
  ); // RQ11 RQ12

  // Multiplier, single cycle
  wire logic                     mul_signed;
  wire logic signed [PROD_W-1:0] prod_s;
  wire logic        [PROD_W-1:0] prod_u;
  wire logic        [PROD_W-1:0] product;

  assign mul_signed = (op_in == ICU_OP_PRODUCT_S);
  assign prod_s  = PROD_W'($signed(source_a_in)) * PROD_W'($signed(source_b_in));
  assign prod_u  = {ZERO_WORD, source_a_in} * {ZERO_WORD, source_b_in};
  assign product = mul_signed ? prod_s : prod_u; // RQ15

  // Divider works on magnitudes; signs restored on completion
  wire logic              div_signed;
  wire logic              div_start;
  wire logic              div_busy;
  wire logic              div_done;
  wire logic [DATA_W-1:0] div_quot;
  wire logic [DATA_W-1:0] div_rem;
  wire logic [DATA_W-1:0] mag_a;
  wire logic [DATA_W-1:0] mag_b;
  wire logic              is_divide;

  assign is_divide  = (op_in == ICU_OP_QUOTIENT_S) || (op_in == ICU_OP_QUOTIENT_U);
  assign div_signed = (op_in == ICU_OP_QUOTIENT_S);
  assign mag_a = (div_signed && source_a_in[DATA_W-1]) ? (ZERO_WORD - source_a_in) : source_a_in;
  assign mag_b = (div_signed && source_b_in[DATA_W-1]) ? (ZERO_WORD - source_b_in) : source_b_in;
  assign div_start = op_valid_in && is_divide && (state == ICU_ST_IDLE);

  icu_divider u_divider (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .start_in      (div_start),
    .dividend_in   (mag_a),
    .divisor_in    (mag_b),
    .busy_out      (div_busy),
    .done_out      (div_done),
    .quotient_out  (div_quot),
    .remainder_out (div_rem)
  );

  wire logic [DATA_W-1:0] fixed_quot;
  wire logic [DATA_W-1:0] fixed_rem;

  assign fixed_quot = neg_quotient ? (ZERO_WORD - div_quot) : div_quot;
  assign fixed_rem  = neg_remainder ? (ZERO_WORD - div_rem) : div_rem;

  // Result selection
  logic [DATA_W-1:0] next_result;
  logic              next_write;
  logic              next_trap;

  always_comb
  begin
    next_result = ZERO_WORD;
    next_write  = 1'b1;
    next_trap   = 1'b0;
    unique case (op_in)
      ICU_OP_SUM_IMM_TRAP, ICU_OP_SUM_REG_TRAP:
      begin
        next_result = sum_value;
        next_trap   = sum_overflow; // RQ2
        next_write  = ~sum_overflow; // RQ20
      end
      ICU_OP_SUM_IMM_NOTRAP, ICU_OP_SUM_REG_NOTRAP: next_result = sum_value; // RQ3
      ICU_OP_DIFF_TRAP:
      begin
        next_result = diff_value;
        next_trap   = diff_overflow; // RQ8
        next_write  = ~diff_overflow; // RQ20
      end
      ICU_OP_DIFF_NOTRAP:   next_result = diff_value; // RQ8
      ICU_OP_LT_IMM_S,
      ICU_OP_LT_REG_S:      next_result = less_s_word; // RQ4 RQ9
      ICU_OP_LT_IMM_U,
      ICU_OP_LT_REG_U:      next_result = less_u_word; // RQ5 RQ9
      ICU_OP_AND_IMM:       next_result = source_a_in & imm_zero_ext; // RQ6
      ICU_OP_OR_IMM:        next_result = source_a_in | imm_zero_ext; // RQ6
      ICU_OP_XOR_IMM:       next_result = source_a_in ^ imm_zero_ext; // RQ6
      ICU_OP_LOAD_TOP_IMM:  next_result = imm_top; // RQ7
      ICU_OP_AND_REG:       next_result = source_a_in & source_b_in; // RQ10
      ICU_OP_OR_REG:        next_result = source_a_in | source_b_in; // RQ10
      ICU_OP_XOR_REG:       next_result = source_a_in ^ source_b_in; // RQ10
      ICU_OP_NOR_REG:       next_result = ~(source_a_in | source_b_in); // RQ10
      ICU_OP_SHL_CONST, ICU_OP_SHR_ZERO_CONST, ICU_OP_SHR_SIGN_CONST,
      ICU_OP_SHL_VAR, ICU_OP_SHR_ZERO_VAR, ICU_OP_SHR_SIGN_VAR:
                            next_result = shift_value; // RQ11 RQ12 RQ13 RQ14
      ICU_OP_READ_TOP:      next_result = product_top_half; // RQ17
      ICU_OP_READ_BOTTOM:   next_result = product_bottom_half; // RQ17
      ICU_OP_PRODUCT_S, ICU_OP_PRODUCT_U, ICU_OP_QUOTIENT_S, ICU_OP_QUOTIENT_U,
      ICU_OP_WRITE_TOP, ICU_OP_WRITE_BOTTOM:
                            next_write = 1'b0;
    endcase
  end

  // Divide sequencing
  always_comb
  begin
    next_state = state;
    unique case (state)
      ICU_ST_IDLE:   if (div_start) next_state = ICU_ST_DIVIDE;
      ICU_ST_DIVIDE: if (div_done) next_state = ICU_ST_DONE;
      ICU_ST_DONE:   next_state = ICU_ST_IDLE;
    endcase
  end

  // Decode must hold a divide until the unit drops busy, on the same edge that updates the pair
  assign busy_out = (state == ICU_ST_DIVIDE) || div_start;

  wire logic single_op;
  assign single_op = op_valid_in && (state == ICU_ST_IDLE) && !is_divide;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state             <= ICU_ST_IDLE;
      write_out         <= 1'b0;
      result_out        <= ZERO_WORD;
      overflow_trap_out <= 1'b0;
      neg_quotient      <= 1'b0;
      neg_remainder     <= 1'b0;
    end
    else
    begin
      state             <= next_state;
      write_out         <= single_op && next_write; // RQ20
      overflow_trap_out <= single_op && next_trap; // RQ2 RQ8
      if (single_op && next_write)
        result_out <= next_result;
      if (div_start)
      begin
        neg_quotient  <= div_signed && (source_a_in[DATA_W-1] ^ source_b_in[DATA_W-1]);
        neg_remainder <= div_signed && source_a_in[DATA_W-1];
      end
    end
  end

  // Special pair updates
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      product_top_half    <= ZERO_WORD;
      product_bottom_half <= ZERO_WORD;
    end
    else if (state == ICU_ST_DIVIDE && div_done)
    begin
      product_top_half    <= fixed_rem; // RQ16
      product_bottom_half <= fixed_quot; // RQ16
    end
    else if (single_op)
    begin
      if (op_in == ICU_OP_PRODUCT_S || op_in == ICU_OP_PRODUCT_U)
      begin
        product_top_half    <= product[PROD_W-1:DATA_W]; // RQ15
        product_bottom_half <= product[DATA_W-1:0]; // RQ15
      end
      if (op_in == ICU_OP_WRITE_TOP)
        product_top_half <= source_a_in; // RQ18
      if (op_in == ICU_OP_WRITE_BOTTOM)
        product_bottom_half <= source_a_in; // RQ18
    end
  end

  assign product_top_half_out    = product_top_half;
  assign product_bottom_half_out = product_bottom_half;

endmodule : icu_compute_unit

// File: icu_props.sv
/*
  Port checker for the integer compute unit.
  Assumes it is bound to icu_compute_unit and sees only that module's ports.
*/
`timescale 1ns/1ps
module icu_props
  import icu_pkg::*;
(
  // Clock, reset and operation
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  input  wire logic                        op_valid_in,
  input  wire icu_pkg::icu_op_e            op_in,
  input  wire logic [icu_pkg::DATA_W-1:0]  source_a_in,
  input  wire logic [icu_pkg::DATA_W-1:0]  source_b_in,
  input  wire logic [icu_pkg::IMM_W-1:0]   immediate_in,
  input  wire logic [icu_pkg::SHAMT_W-1:0] shift_count_in,
  // Results
  input  wire logic                        busy_out,
  input  wire logic                        write_out,
  input  wire logic [icu_pkg::DATA_W-1:0]  result_out,
  input  wire logic                        overflow_trap_out,
  input  wire logic [icu_pkg::DATA_W-1:0]  product_top_half_out,
  input  wire logic [icu_pkg::DATA_W-1:0]  product_bottom_half_out
);
  import icu_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Ops offered during a running divide are ignored, so they must not count
  wire logic        take = op_valid_in && !busy_out;
  wire logic [31:0] diff = source_a_in - source_b_in;
  wire logic        diff_ovf = (source_a_in[31] != source_b_in[31]) && (diff[31] != source_a_in[31]);

  chk_trap_blocks_write: assert property (!(write_out && overflow_trap_out))
    else $error("write and trap pulsed together");
  chk_notrap_stays_low: assert property (take && op_in inside {ICU_OP_SUM_IMM_NOTRAP,
    ICU_OP_SUM_REG_NOTRAP, ICU_OP_DIFF_NOTRAP, ICU_OP_LT_IMM_U} |=> !overflow_trap_out)
    else $error("non-trapping op raised a trap");
  chk_diff_trap_flag: assert property (take && op_in == ICU_OP_DIFF_TRAP |=>
    overflow_trap_out == $past(diff_ovf) && write_out == !$past(diff_ovf))
    else $error("subtract overflow handling wrong");
  chk_sum_reg_value: assert property (take && op_in == ICU_OP_SUM_REG_NOTRAP |=>
    write_out && result_out == $past(source_a_in) + $past(source_b_in))
    else $error("register sum wrong");
  chk_nor_reg_value: assert property (take && op_in == ICU_OP_NOR_REG |=>
    write_out && result_out == ~($past(source_a_in) | $past(source_b_in)))
    else $error("nor result wrong");
  chk_load_top_value: assert property (take && op_in == ICU_OP_LOAD_TOP_IMM |=>
    write_out && result_out == {$past(immediate_in), ZERO_HALF})
    else $error("load top result wrong");
  chk_shl_const_value: assert property (take && op_in == ICU_OP_SHL_CONST |=>
    result_out == $past(source_b_in) << $past(shift_count_in))
    else $error("constant left shift wrong");
  chk_uprod_pair_value: assert property (take && op_in == ICU_OP_PRODUCT_U |=>
    {product_top_half_out, product_bottom_half_out} ==
    {32'h0000_0000, $past(source_a_in)} * {32'h0000_0000, $past(source_b_in)})
    else $error("unsigned product wrong");
  chk_write_top_copy: assert property (take && op_in == ICU_OP_WRITE_TOP |=>
    !write_out && product_top_half_out == $past(source_a_in))
    else $error("write top copy wrong");

  cover property (take && op_in == ICU_OP_DIFF_TRAP ##1 overflow_trap_out);
  cover property ($fell(busy_out));
  cover property (take && op_in == ICU_OP_PRODUCT_S);
endmodule : icu_props

bind icu_compute_unit icu_props icu_props_i (.clk_in, .rst_n_in, .op_valid_in, .op_in,
  .source_a_in, .source_b_in, .immediate_in, .shift_count_in, .busy_out, .write_out,
  .result_out, .overflow_trap_out, .product_top_half_out, .product_bottom_half_out);

// File: icu_regfile_model.sv
/*
  Register file side of the compute unit: takes each written result.
  Assumes result data is meaningful only while the write strobe is high.
*/
`timescale 1ns/1ps
module icu_regfile_model
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Write port from the compute unit
  input  wire logic        write_in,
  input  wire logic [31:0] data_in,
  input  wire logic        trap_in,
  // Observed state
  output int               writes_out,
  output int               traps_out,
  output logic [31:0]      dest_out
);
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      writes_out <= 0;
      traps_out  <= 0;
      dest_out   <= 32'h0000_0000;
    end
    else
    begin
      // A trapped result must never land in the destination
      if (write_in && !trap_in) dest_out <= data_in;
      if (write_in) writes_out <= writes_out + 1;
      if (trap_in) traps_out <= traps_out + 1;
    end
endmodule : icu_regfile_model

// File: test_integer_compute_unit.sv
/*
  Self-checking bench for the integer compute unit with a reference model.
  Assumes the package op order and the one-cycle result latency.
*/
`timescale 1ns/1ps
module test_integer_compute_unit;
  import icu_pkg::*;
  logic        clk_in, rst_n_in, op_valid_in, busy_out, write_out, overflow_trap_out;
  icu_op_e     op_in;
  logic [31:0] source_a_in, source_b_in, result_out, product_top_half_out;
  logic [31:0] product_bottom_half_out, m_top, m_bot, e_res, last_wr, rng, m_dest;
  logic [15:0] immediate_in;
  logic [4:0]  shift_count_in;
  logic        e_wr, e_trap;
  int          err_count, tests_run, n_wr, n_trap, m_writes, m_traps;

  icu_compute_unit icu_compute_unit_i (.clk_in, .rst_n_in, .op_valid_in, .op_in,
    .source_a_in, .source_b_in, .immediate_in, .shift_count_in, .busy_out, .write_out,
    .result_out, .overflow_trap_out, .product_top_half_out, .product_bottom_half_out);
  icu_regfile_model icu_regfile_model_i (.clk_in, .rst_n_in, .write_in(write_out),
    .data_in(result_out), .trap_in(overflow_trap_out), .writes_out(m_writes),
    .traps_out(m_traps), .dest_out(m_dest));

  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {1'b0, x[31:1]} ^ (x[0] ? 32'h8020_0003 : 32'h0000_0000);
  endfunction : lfsr

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic model(input icu_op_e op, input logic [31:0] a, b, input logic [15:0] im,
                       input logic [4:0] sh);
    logic [31:0] se;
    longint      r;
    se = {{16{im[15]}}, im};
    r = 0;
    case (op)
      ICU_OP_SUM_IMM_TRAP, ICU_OP_SUM_IMM_NOTRAP: r = $signed(a) + $signed(se);
      ICU_OP_SUM_REG_TRAP, ICU_OP_SUM_REG_NOTRAP: r = $signed(a) + $signed(b);
      ICU_OP_DIFF_TRAP, ICU_OP_DIFF_NOTRAP:       r = $signed(a) - $signed(b);
      ICU_OP_LT_IMM_S:       e_res = {31'h0, $signed(a) < $signed(se)};
      ICU_OP_LT_IMM_U:       e_res = {31'h0, a < se};
      ICU_OP_AND_IMM:        e_res = a & {16'h0000, im};
      ICU_OP_OR_IMM:         e_res = a | {16'h0000, im};
      ICU_OP_XOR_IMM:        e_res = a ^ {16'h0000, im};
      ICU_OP_LOAD_TOP_IMM:   e_res = {im, 16'h0000};
      ICU_OP_LT_REG_S:       e_res = {31'h0, $signed(a) < $signed(b)};
      ICU_OP_LT_REG_U:       e_res = {31'h0, a < b};
      ICU_OP_AND_REG:        e_res = a & b;
      ICU_OP_OR_REG:         e_res = a | b;
      ICU_OP_XOR_REG:        e_res = a ^ b;
      ICU_OP_NOR_REG:        e_res = ~(a | b);
      ICU_OP_SHL_CONST:      e_res = b << sh;
      ICU_OP_SHR_ZERO_CONST: e_res = b >> sh;
      ICU_OP_SHR_SIGN_CONST: e_res = $signed(b) >>> sh;
      ICU_OP_SHL_VAR:        e_res = b << a[4:0];
      ICU_OP_SHR_ZERO_VAR:   e_res = b >> a[4:0];
      ICU_OP_SHR_SIGN_VAR:   e_res = $signed(b) >>> a[4:0];
      ICU_OP_PRODUCT_S:      {m_top, m_bot} = $signed(a) * $signed(b);
      ICU_OP_PRODUCT_U:      {m_top, m_bot} = {32'h0000_0000, a} * {32'h0000_0000, b};
      ICU_OP_QUOTIENT_S:     {m_top, m_bot} = {$signed(a) % $signed(b), $signed(a) / $signed(b)};
      ICU_OP_QUOTIENT_U:     {m_top, m_bot} = {a % b, a / b};
      ICU_OP_READ_TOP:       e_res = m_top;
      ICU_OP_READ_BOTTOM:    e_res = m_bot;
      ICU_OP_WRITE_TOP:      m_top = a;
      default:               m_bot = a;
    endcase
    if (op inside {[ICU_OP_SUM_IMM_TRAP:ICU_OP_SUM_IMM_NOTRAP], [ICU_OP_SUM_REG_TRAP:ICU_OP_DIFF_NOTRAP]})
      e_res = r[31:0];
    // Overflow shows as the wide sum differing from its 32-bit sign extension
    e_trap = op inside {ICU_OP_SUM_IMM_TRAP, ICU_OP_SUM_REG_TRAP, ICU_OP_DIFF_TRAP} && r != longint'($signed(e_res));
    e_wr = !e_trap && !(op inside {[ICU_OP_PRODUCT_S:ICU_OP_QUOTIENT_U], ICU_OP_WRITE_TOP, ICU_OP_WRITE_BOTTOM});
  endtask : model

  task automatic do_op(input icu_op_e op, input logic [31:0] a, b, input logic [15:0] im,
                       input logic [4:0] sh);
    int k;
    model(op, a, b, im, sh);
    op_valid_in = 1'b1;
    op_in = op;
    source_a_in = a;
    source_b_in = b;
    immediate_in = im;
    shift_count_in = sh;
    @(negedge clk_in);
    if (op inside {ICU_OP_QUOTIENT_S, ICU_OP_QUOTIENT_U})
    begin
      k = 0;
      while (busy_out === 1'b1 && k < 100)
      begin
        @(negedge clk_in);
        k++;
      end
      chk("divide_busy_cycles", 32'd33, 32'(k));
      op_valid_in = 1'b0;
      repeat (2) @(negedge clk_in);
    end
    chk("write_out", 32'(e_wr), 32'(write_out));
    chk("overflow_trap_out", 32'(e_trap), 32'(overflow_trap_out));
    if (e_wr) chk("result_out", e_res, result_out);
    chk("top_half", m_top, product_top_half_out);
    chk("bottom_half", m_bot, product_bottom_half_out);
    if (e_wr) last_wr = e_res;
    n_wr += int'(e_wr);
    n_trap += int'(e_trap);
  endtask : do_op

  task automatic run_random;
    logic [31:0] a, b;
    for (int i = 0; i < 320; i++)
    begin
      rng = lfsr(rng);
      a = rng;
      rng = lfsr(rng);
      b = rng;
      rng = lfsr(rng);
      if (i < 32) rng[4:0] = i[4:0];
      // Keep divisors off zero and minus one, where results are undefined
      if (rng[4:1] == 4'hD) b[1:0] = 2'b10;
      do_op(icu_op_e'(rng[4:0]), a, b, rng[20:5], rng[25:21]);
    end
    op_valid_in = 1'b0;
  endtask : run_random

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  initial
  begin
    #240us;
    err_count++;
    give_verdict;
  end

  initial
  begin
    {rst_n_in, op_valid_in, source_a_in, source_b_in, immediate_in, shift_count_in} = '0;
    op_in = ICU_OP_SUM_IMM_TRAP;
    {m_top, m_bot, last_wr, e_res} = '0;
    rng = 32'd77;
    repeat (20) @(negedge clk_in);
    rst_n_in = 1'b1;
    chk("reset_outputs", 32'h0, result_out | product_top_half_out | product_bottom_half_out);
    $display("test reset done");
    do_op(ICU_OP_SUM_REG_TRAP, 32'h7FFF_FFFF, 32'h0000_0001, 16'h0000, 5'h00);
    do_op(ICU_OP_SUM_REG_TRAP, 32'h8000_0000, 32'hFFFF_FFFF, 16'h0000, 5'h00);
    do_op(ICU_OP_SUM_IMM_TRAP, 32'h7FFF_FFFF, 32'h0000_0000, 16'h0001, 5'h00);
    do_op(ICU_OP_SUM_IMM_TRAP, 32'h8000_0000, 32'h0000_0000, 16'h8000, 5'h00);
    do_op(ICU_OP_SUM_IMM_NOTRAP, 32'h7FFF_FFFF, 32'h0000_0000, 16'h0001, 5'h00);
    do_op(ICU_OP_DIFF_TRAP, 32'h0000_0000, 32'h8000_0000, 16'h0000, 5'h00);
    do_op(ICU_OP_DIFF_TRAP, 32'h8000_0000, 32'h0000_0000, 16'h0000, 5'h00);
    do_op(ICU_OP_DIFF_NOTRAP, 32'h8000_0000, 32'h0000_0001, 16'h0000, 5'h00);
    do_op(ICU_OP_LT_IMM_U, 32'h0001_0000, 32'h0000_0000, 16'hFFFF, 5'h00);
    do_op(ICU_OP_LT_IMM_S, 32'h0000_0000, 32'h0000_0000, 16'hFFFF, 5'h00);
    do_op(ICU_OP_AND_IMM, 32'hFFFF_FFFF, 32'h0000_0000, 16'h8001, 5'h00);
    do_op(ICU_OP_SHR_SIGN_CONST, 32'h0000_0000, 32'h8000_0000, 16'h0000, 5'h1F);
    do_op(ICU_OP_SHR_SIGN_VAR, 32'hFFFF_FFE4, 32'h8000_0000, 16'h0000, 5'h00);
    do_op(ICU_OP_QUOTIENT_S, 32'hFFFF_FFF9, 32'h0000_0002, 16'h0000, 5'h00);
    do_op(ICU_OP_READ_TOP, 32'h0000_0000, 32'h0000_0000, 16'h0000, 5'h00);
    $display("test directed done");
    run_random;
    @(negedge clk_in);
    $display("test random done");
    chk("rf_writes", 32'(n_wr), 32'(m_writes));
    chk("rf_traps", 32'(n_trap), 32'(m_traps));
    chk("rf_dest", last_wr, m_dest);
    give_verdict;
  end
endmodule : test_integer_compute_unit
